// ### core/dprt_pkg.sv
package dprt_pkg;

	// core clock period, used to turn analog times into cycles
	localparam int CLK_PERIOD_PS = 10000;

	// latency defaults in link clocks, burst length default in data beats
	localparam int AL_DEF = 0;
	localparam int CL_DEF = 4;
	localparam int BL_DEF = 4;

	// analog times in ns; plain defaults, tune per speed grade
	localparam int T_RAS_NS = 45;
	localparam int T_RTP_NS = 8;
	localparam int T_WR_NS  = 15;
	localparam int T_RP_NS  = 15;
	localparam int T_RFC_NS = 128;

	localparam int NBANK = 8;  // eight banks
	localparam int ROW_W = 13; // refresh row counter width
	localparam int CNT_W = 16; // analog delay counter width
	localparam int CKC_W = 8;  // link clock tick counter width

	localparam logic [ROW_W-1:0] ROW_RST = 13'h0000; // refresh row after reset

	// least time in ns to whole core cycles, rounded up, never below one
	function automatic int ns2cyc(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction : ns2cyc

	localparam int T_RAS_CYC = ns2cyc(T_RAS_NS);
	localparam int T_RTP_CYC = ns2cyc(T_RTP_NS);
	localparam int T_WR_CYC  = ns2cyc(T_WR_NS);
	localparam int T_RP_CYC  = ns2cyc(T_RP_NS);
	localparam int T_RFC_CYC = ns2cyc(T_RFC_NS);

	// decoded command kinds
	typedef enum logic [2:0] {C_NOP, C_ACT, C_RD, C_WR, C_PRE, C_REF} dprt_cmd_t;

	// per-bank states
	typedef enum logic [2:0] {B_IDLE, B_ACTIVE, B_AP_CK, B_AP_NS, B_PRE, B_REF} dprt_bank_st_t;

endpackage : dprt_pkg

// ### core/dprt_bank_if.sv
`timescale 1ns/1ps
interface dprt_bank_if;
	logic                stb;     // one-cycle command strobe
	dprt_pkg::dprt_cmd_t cmd;     // command kind
	logic                a10;     // a10 sampled with the command
	logic                hit;     // bank address selects this bank
	logic                tick;    // one pulse per link clock edge
	logic                open_st; // bank row open
	logic                pre_st;  // precharge or refresh in progress
	logic                idle;    // bank precharged and idle
	logic                ap_go;   // internal auto-precharge starts

	modport ctrl (output stb, cmd, a10, hit, tick, input open_st, pre_st, idle, ap_go);
	modport bank (input stb, cmd, a10, hit, tick, output open_st, pre_st, idle, ap_go);
endinterface : dprt_bank_if

// ### core/dprt_bank.sv
`timescale 1ns/1ps
module dprt_bank #(
	parameter int AL = dprt_pkg::AL_DEF,
	parameter int CL = dprt_pkg::CL_DEF,
	parameter int BL = dprt_pkg::BL_DEF
) (
	input wire logic       clock,
	input wire logic       rst_n,
	dprt_bank_if.bank      bif
);
	localparam int CW = dprt_pkg::CNT_W;
	localparam int KW = dprt_pkg::CKC_W;
	localparam logic [KW-1:0] RD_GO = KW'(AL + BL / 2);          // read ap edge
	localparam logic [KW-1:0] WR_GO = KW'((AL + CL - 1) + BL / 2); // end of write data
	localparam logic [KW-1:0] PF_PT = KW'((BL == 8) ? AL + 2 : AL); // last prefetch

	dprt_pkg::dprt_bank_st_t st_q;        // bank state
	logic                    is_rd_q;     // pending ap belongs to a read
	logic [KW-1:0]           ck_cnt_q;    // link clocks since read/write
	logic [CW-1:0]           ras_cnt_q;   // remaining row-active time
	logic [CW-1:0]           rtp_cnt_q;   // remaining read-to-precharge time
	logic                    rtp_ld_q;    // read-to-precharge count started
	logic [CW-1:0]           wr_cnt_q;    // remaining write recovery
	logic [CW-1:0]           rp_cnt_q;    // remaining precharge or refresh time
	logic                    rw_hit;      // read or write to this bank
	logic                    pre_hit;     // precharge to this bank or all
	logic                    ck_done;     // clock part of the ap delay met
	logic                    ap_go;       // internal precharge starts now

	assign rw_hit  = bif.stb && bif.hit && (bif.cmd == dprt_pkg::C_RD || bif.cmd == dprt_pkg::C_WR);
	assign pre_hit = bif.stb && bif.cmd == dprt_pkg::C_PRE && (bif.a10 || bif.hit);
	assign ck_done = ck_cnt_q >= (is_rd_q ? RD_GO : WR_GO);
	// gate on row-active and on recovery; both may push the start out
	assign ap_go   = st_q == dprt_pkg::B_AP_NS && ras_cnt_q == '0
		&& (is_rd_q ? (rtp_ld_q && rtp_cnt_q == '0) : wr_cnt_q == '0);

	// bank state machine
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_q <= dprt_pkg::B_IDLE;
		end else begin
			case (st_q)
				dprt_pkg::B_IDLE: begin
					if (bif.stb && bif.hit && bif.cmd == dprt_pkg::C_ACT) begin
						st_q <= dprt_pkg::B_ACTIVE;
					end else if (bif.stb && bif.cmd == dprt_pkg::C_REF) begin
						st_q <= dprt_pkg::B_REF;
					end
				end
				dprt_pkg::B_ACTIVE: begin
					// a10 low leaves the row open after the burst
					if (rw_hit && bif.a10) begin
						st_q <= dprt_pkg::B_AP_CK;
					end else if (pre_hit) begin
						st_q <= dprt_pkg::B_PRE;
					end
				end
				dprt_pkg::B_AP_CK: begin
					if (ck_done) begin
						st_q <= dprt_pkg::B_AP_NS;
					end
				end
				dprt_pkg::B_AP_NS: begin
					if (ap_go) begin
						st_q <= dprt_pkg::B_PRE;
					end
				end
				dprt_pkg::B_PRE, dprt_pkg::B_REF: begin
					// leave on the last counted cycle so the busy time is exactly the load
					if (rp_cnt_q <= CW'(1)) begin
						st_q <= dprt_pkg::B_IDLE;
					end
				end
				default: begin
					st_q <= dprt_pkg::B_IDLE;
				end
			endcase
		end
	end

	// read/write kind and link clock count of the pending ap
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			is_rd_q  <= 1'b0;
			ck_cnt_q <= '0;
		end else if (st_q == dprt_pkg::B_ACTIVE && rw_hit && bif.a10) begin
			is_rd_q  <= bif.cmd == dprt_pkg::C_RD;
			ck_cnt_q <= '0;
		end else if (st_q == dprt_pkg::B_AP_CK && bif.tick && !ck_done) begin
			ck_cnt_q <= ck_cnt_q + 1'b1;
		end
	end

	// row-active time, started by activate
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ras_cnt_q <= '0;
		end else if (st_q == dprt_pkg::B_IDLE && bif.stb && bif.hit && bif.cmd == dprt_pkg::C_ACT) begin
			ras_cnt_q <= CW'(dprt_pkg::T_RAS_CYC);
		end else if (ras_cnt_q != '0) begin
			ras_cnt_q <= ras_cnt_q - 1'b1;
		end
	end

	// read-to-precharge time, from the last prefetch of the read
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rtp_ld_q  <= 1'b0;
			rtp_cnt_q <= '0;
		end else if (st_q != dprt_pkg::B_AP_CK && st_q != dprt_pkg::B_AP_NS) begin
			rtp_ld_q  <= 1'b0;
		end else if (is_rd_q && !rtp_ld_q && ck_cnt_q == PF_PT) begin
			rtp_ld_q  <= 1'b1;
			rtp_cnt_q <= CW'(dprt_pkg::T_RTP_CYC);
		end else if (rtp_cnt_q != '0) begin
			rtp_cnt_q <= rtp_cnt_q - 1'b1;
		end
	end

	// write recovery, from the end of the write data
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_cnt_q <= '0;
		end else if (st_q == dprt_pkg::B_AP_CK && ck_done && !is_rd_q) begin
			wr_cnt_q <= CW'(dprt_pkg::T_WR_CYC);
		end else if (wr_cnt_q != '0) begin
			wr_cnt_q <= wr_cnt_q - 1'b1;
		end
	end

	// precharge period counts from the real internal start, not a link edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rp_cnt_q <= '0;
		end else if (ap_go || (st_q == dprt_pkg::B_ACTIVE && pre_hit && !(rw_hit && bif.a10))) begin
			rp_cnt_q <= CW'(dprt_pkg::T_RP_CYC);
		end else if (st_q == dprt_pkg::B_IDLE && bif.stb && bif.cmd == dprt_pkg::C_REF) begin
			rp_cnt_q <= CW'(dprt_pkg::T_RFC_CYC);
		end else if (rp_cnt_q != '0) begin
			rp_cnt_q <= rp_cnt_q - 1'b1;
		end
	end

	assign bif.open_st = st_q == dprt_pkg::B_ACTIVE || st_q == dprt_pkg::B_AP_CK
		|| st_q == dprt_pkg::B_AP_NS;
	assign bif.pre_st  = st_q == dprt_pkg::B_PRE || st_q == dprt_pkg::B_REF;
	assign bif.idle    = st_q == dprt_pkg::B_IDLE;
	assign bif.ap_go   = ap_go;

	property p_norm_open;
		@(posedge clock) disable iff (!rst_n)
		(st_q == dprt_pkg::B_ACTIVE && rw_hit && !bif.a10) |=> st_q == dprt_pkg::B_ACTIVE;
	endproperty
	a_norm_open: assert property (p_norm_open) else $error("row closed without a10");

	property p_ap_engage;
		@(posedge clock) disable iff (!rst_n)
		(st_q == dprt_pkg::B_ACTIVE && rw_hit && bif.a10) |=> st_q == dprt_pkg::B_AP_CK;
	endproperty
	a_ap_engage: assert property (p_ap_engage) else $error("auto-precharge not engaged");

	property p_ras_hold;
		@(posedge clock) disable iff (!rst_n) ap_go |-> ras_cnt_q == '0;
	endproperty
	a_ras_hold: assert property (p_ras_hold) else $error("precharge before row-active time");

	property p_rtp_hold;
		@(posedge clock) disable iff (!rst_n)
		(ap_go && is_rd_q) |-> (rtp_ld_q && rtp_cnt_q == '0 && ck_cnt_q >= RD_GO);
	endproperty
	a_rtp_hold: assert property (p_rtp_hold) else $error("read ap too early");

	property p_prefetch_gap;
		@(posedge clock) disable iff (!rst_n)
		(ap_go && is_rd_q) |-> ck_cnt_q >= PF_PT + 8'h02;
	endproperty
	a_prefetch_gap: assert property (p_prefetch_gap) else $error("ap within two clocks of prefetch");

	property p_wr_recov;
		@(posedge clock) disable iff (!rst_n)
		(ap_go && !is_rd_q) |-> (wr_cnt_q == '0 && ck_cnt_q >= WR_GO);
	endproperty
	a_wr_recov: assert property (p_wr_recov) else $error("write ap before recovery");

	property p_rp_start;
		@(posedge clock) disable iff (!rst_n)
		ap_go |=> (st_q == dprt_pkg::B_PRE && rp_cnt_q == CW'(dprt_pkg::T_RP_CYC));
	endproperty
	a_rp_start: assert property (p_rp_start) else $error("precharge period not started");

	c_ap_rd: cover property (@(posedge clock) disable iff (!rst_n) ap_go && is_rd_q);
	c_ap_wr: cover property (@(posedge clock) disable iff (!rst_n) ap_go && !is_rd_q);
endmodule : dprt_bank

// ### core/dprt_top.sv
`timescale 1ns/1ps
// Functional notes
// - a10 low keeps bank open after burst
// - a10 high engages auto-precharge
// - read ap starts AL+BL/2 after command
// - read ap waits for tRAS and tRTP
// - tRP counts from actual internal precharge
// - ap never within two clocks of prefetch
// - write ap waits for burst plus tWR
// - ap held internally until tRAS met
// - refresh decoded as cs ras cas low
// - refresh uses internal row, leaves idle
// - write latency is AL+CL-1
module dprt_top #(
	parameter int AL = dprt_pkg::AL_DEF, // additive latency
	parameter int CL = dprt_pkg::CL_DEF, // cas latency
	parameter int BL = dprt_pkg::BL_DEF  // burst length, 4 or 8
) (
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	input  wire logic                       ck,
	input  wire logic                       cs_n,
	input  wire logic                       ras_n,
	input  wire logic                       cas_n,
	input  wire logic                       we_n,
	input  wire logic                       a10,
	input  wire logic [2:0]                 ba,
	output logic [dprt_pkg::NBANK-1:0]      bank_open,
	output logic [dprt_pkg::NBANK-1:0]      bank_busy,
	output logic [dprt_pkg::NBANK-1:0]      ap_start,
	output logic                            all_idle,
	output logic [dprt_pkg::ROW_W-1:0]      refresh_row
);
	localparam int NB = dprt_pkg::NBANK;

	// ---- link domain, clocked by the command clock ----
	logic                rst_l_meta_q; // reset into link domain, stage one
	logic                rst_l_n_q;    // reset into link domain, usable
	dprt_pkg::dprt_cmd_t l_cmd_d;      // decoded pin command
	dprt_pkg::dprt_cmd_t l_cmd_q;      // last valid command, held stable
	logic                l_a10_q;      // a10 with that command
	logic [2:0]          l_ba_q;       // bank address with that command
	logic                l_tog_q;      // flips once per valid command
	logic                l_tick_q;     // flips every link clock edge

	// core reset is synchronous, so bring it over with two stages
	always_ff @(posedge ck) begin
		rst_l_meta_q <= rst_n;
		rst_l_n_q    <= rst_l_meta_q;
	end

	// pin decode; deselect and nop give no command
	always_comb begin
		l_cmd_d = dprt_pkg::C_NOP;
		if (!cs_n) begin
			case ({ras_n, cas_n, we_n})
				3'b011: l_cmd_d = dprt_pkg::C_ACT;
				3'b101: l_cmd_d = dprt_pkg::C_RD;
				3'b100: l_cmd_d = dprt_pkg::C_WR;
				3'b010: l_cmd_d = dprt_pkg::C_PRE;
				3'b001: l_cmd_d = dprt_pkg::C_REF;
				default: l_cmd_d = dprt_pkg::C_NOP;
			endcase
		end
	end

	// hold each command until the next one so the core can read it
	always_ff @(posedge ck) begin
		if (!rst_l_n_q) begin
			l_cmd_q <= dprt_pkg::C_NOP;
			l_a10_q <= 1'b0;
			l_ba_q  <= 3'h0;
			l_tog_q <= 1'b0;
		end else if (l_cmd_d != dprt_pkg::C_NOP) begin
			l_cmd_q <= l_cmd_d;
			l_a10_q <= a10;
			// refresh ignores the address bus
			l_ba_q  <= (l_cmd_d == dprt_pkg::C_REF) ? 3'h0 : ba;
			l_tog_q <= ~l_tog_q;
		end
	end

	// link clock tick for clock-counted latencies
	always_ff @(posedge ck) begin
		if (!rst_l_n_q) begin
			l_tick_q <= 1'b0;
		end else begin
			l_tick_q <= ~l_tick_q;
		end
	end

	// ---- core domain ----
	logic [2:0]          tk_s_q;  // tick toggle synchroniser and edge stage
	logic [2:0]          cm_s_q;  // command toggle synchroniser and edge stage
	logic                tick;    // one pulse per link clock
	logic                c_stb_q; // captured command strobe
	dprt_pkg::dprt_cmd_t c_cmd_q; // captured command
	logic                c_a10_q; // captured a10
	logic [2:0]          c_ba_q;  // captured bank address
	logic [NB-1:0]       b_open;  // per-bank open state
	logic [NB-1:0]       b_pre;   // per-bank precharge or refresh
	logic [NB-1:0]       b_idle;  // per-bank idle
	logic [NB-1:0]       b_go;    // per-bank ap start

	// toggles cross with two flops; the second and the third (edge) stage feed logic
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tk_s_q <= 3'h0;
			cm_s_q <= 3'h0;
		end else begin
			tk_s_q <= {tk_s_q[1:0], l_tick_q};
			cm_s_q <= {cm_s_q[1:0], l_tog_q};
		end
	end

	assign tick = tk_s_q[2] ^ tk_s_q[1];

	// the held command word is stable once its toggle has been seen
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			c_stb_q <= 1'b0;
			c_cmd_q <= dprt_pkg::C_NOP;
			c_a10_q <= 1'b0;
			c_ba_q  <= 3'h0;
		end else begin
			c_stb_q <= cm_s_q[2] ^ cm_s_q[1];
			if (cm_s_q[2] ^ cm_s_q[1]) begin
				c_cmd_q <= l_cmd_q;
				c_a10_q <= l_a10_q;
				c_ba_q  <= l_ba_q;
			end
		end
	end

	// one timing engine per bank
	for (genvar g = 0; g < NB; g++) begin : g_bank
		dprt_bank_if u_if ();
		assign u_if.stb  = c_stb_q;
		assign u_if.cmd  = c_cmd_q;
		assign u_if.a10  = c_a10_q;
		assign u_if.hit  = c_ba_q == 3'(g);
		assign u_if.tick = tick;
		assign b_open[g] = u_if.open_st;
		assign b_pre[g]  = u_if.pre_st;
		assign b_idle[g] = u_if.idle;
		assign b_go[g]   = u_if.ap_go;
		dprt_bank #(.AL(AL), .CL(CL), .BL(BL)) u_bank (
			.clock (clock),
			.rst_n (rst_n),
			.bif   (u_if.bank)
		);
	end

	// internal refresh row counter; external address plays no part
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			refresh_row <= dprt_pkg::ROW_RST;
		end else if (c_stb_q && c_cmd_q == dprt_pkg::C_REF && &b_idle) begin
			refresh_row <= refresh_row + 1'b1;
		end
	end

	// registered status outputs
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			bank_open <= '0;
			bank_busy <= '0;
			ap_start  <= '0;
			all_idle  <= 1'b1;
		end else begin
			bank_open <= b_open;
			bank_busy <= b_pre;
			ap_start  <= b_go;
			all_idle  <= &b_idle;
		end
	end

	property p_ref_decode;
		@(posedge ck) disable iff (!rst_l_n_q)
		(!cs_n && !ras_n && !cas_n && we_n) |=> (l_cmd_q == dprt_pkg::C_REF && l_tog_q != $past(l_tog_q));
	endproperty
	a_ref_decode: assert property (p_ref_decode) else $error("refresh not decoded");

	property p_ref_row;
		@(posedge clock) disable iff (!rst_n)
		(c_stb_q && c_cmd_q == dprt_pkg::C_REF && &b_idle)
			|=> (refresh_row == dprt_pkg::ROW_W'($past(refresh_row) + 1'b1) && !(&b_idle));
	endproperty
	a_ref_row: assert property (p_ref_row) else $error("refresh row not advanced");

	c_ref: cover property (@(posedge clock) disable iff (!rst_n) c_stb_q && c_cmd_q == dprt_pkg::C_REF);
endmodule : dprt_top

// ### dv/dprt_ctrl_model.sv
`timescale 1ns/1ps
// behavioural memory controller: makes the link clock, drives command pins
module dprt_ctrl_model (
	output logic       ck,
	output logic       cs_n,
	output logic       ras_n,
	output logic       cas_n,
	output logic       we_n,
	output logic       a10,
	output logic [2:0] ba
);
	realtime t_cmd; // time of the edge that took the last command

	// link clock runs free, as the device needs a stable clock; phase unrelated
	initial begin
		ck = 1'b0;
		#3.7;
		forever #16 ck = ~ck;
	end

	// deselected at time zero
	initial begin
		cs_n = 1'b1;
		{ras_n, cas_n, we_n} = 3'h7;
		a10 = 1'b0;
		ba = 3'h0;
	end

	// one command, then gap idle edges; spacing is chosen by the caller
	task automatic issue(input logic [2:0] pat, input logic [2:0] b, input logic a,
		input int gap);
		int g;
		g = (gap < 1) ? 1 : gap;
		@(posedge ck);
		cs_n <= 1'b0;
		{ras_n, cas_n, we_n} <= pat;
		ba <= b;
		a10 <= a;
		@(posedge ck);
		t_cmd = $realtime;
		// deselected pins show the inverse, so no stale value looks valid
		cs_n <= 1'b1;
		{ras_n, cas_n, we_n} <= ~pat;
		ba <= ~b;
		a10 <= ~a;
		repeat (g) @(posedge ck);
	endtask : issue
endmodule : dprt_ctrl_model

// ### dv/ddr2_precharge_refresh_timing_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin errors++; \
	$display("ERROR at %0t: %s", $time, msg); end end
module ddr2_precharge_refresh_timing_tb;
	localparam logic [2:0] P_ACT = 3'h3; // ras cas we patterns
	localparam logic [2:0] P_RD  = 3'h5;
	localparam logic [2:0] P_WR  = 3'h4;
	localparam logic [2:0] P_PRE = 3'h2;
	localparam logic [2:0] P_REF = 3'h1;
	localparam int  AL = 0;
	localparam int  CL = 4;
	localparam int  BL = 4;
	localparam real TCK = 32.0; // link period, ns
	localparam real TCO = 10.0; // core period, ns

	logic                         clock;
	logic                         rst_n;
	logic                         ck, cs_n, ras_n, cas_n, we_n, a10;
	logic [2:0]                   ba;
	logic [dprt_pkg::NBANK-1:0]   bank_open, bank_busy, ap_start;
	logic                         all_idle;
	logic [dprt_pkg::ROW_W-1:0]   refresh_row, r0;
	int                           errors, checks, cycles, n;
	realtime                      t;

	dprt_ctrl_model dprt_ctrl_model_inst (.ck(ck), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .a10(a10), .ba(ba));

	dprt_top #(.AL(AL), .CL(CL), .BL(BL)) dprt_top_inst (.clock(clock), .rst_n(rst_n),
		.ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .a10(a10),
		.ba(ba), .bank_open(bank_open), .bank_busy(bank_busy), .ap_start(ap_start),
		.all_idle(all_idle), .refresh_row(refresh_row));

	// core clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	task automatic cmd(input logic [2:0] p, input logic [2:0] b, input logic a, input int g);
		dprt_ctrl_model_inst.issue(p, b, a, g);
	endtask : cmd

	// time of the next auto-precharge start in bank b, bounded wait
	task automatic wait_ap(input int b, output realtime ta);
		ta = 0.0;
		for (int i = 0; i < 200; i++) begin
			@(posedge clock);
			#1;
			if (ap_start[b] === 1'b1) begin
				ta = $realtime - 1.0;
				break;
			end
		end
		`CHK(ta > 0.0, 1'b1, "auto-precharge never started")
	endtask : wait_ap

	// cycles within a window where every masked bank reads busy
	task automatic count_busy(input logic [7:0] m, input int win, output int c);
		c = 0;
		repeat (win) begin
			@(posedge clock);
			#1;
			if ((bank_busy & m) === m) c++;
		end
	endtask : count_busy

	task automatic sc_reset;
		`CHK(bank_open, 8'h00, "open after reset")
		`CHK(bank_busy, 8'h00, "busy after reset")
		`CHK(ap_start, 8'h00, "ap after reset")
		`CHK(all_idle, 1'b1, "idle after reset")
		`CHK(refresh_row, dprt_pkg::ROW_RST, "row after reset")
	endtask : sc_reset

	// plain read leaves the row open until an explicit precharge
	task automatic sc_read_open;
		cmd(P_ACT, 3'h1, 1'b0, 1);
		cmd(P_RD, 3'h1, 1'b0, 4);
		repeat (30) @(posedge clock);
		`CHK(bank_open[1], 1'b1, "plain read closed bank")
		`CHK(ap_start[1], 1'b0, "plain read started precharge")
		cmd(P_PRE, 3'h1, 1'b0, 1);
		repeat (dprt_pkg::T_RP_CYC + 12) @(posedge clock);
		`CHK(bank_open[1], 1'b0, "precharge left bank open")
		`CHK(all_idle, 1'b1, "not idle after precharge")
	endtask : sc_read_open

	// read with auto-precharge, issued right after activate
	task automatic sc_read_ap;
		cmd(P_ACT, 3'h2, 1'b0, 1);
		cmd(P_RD, 3'h2, 1'b1, 1);
		wait_ap(2, t);
		t = t - dprt_ctrl_model_inst.t_cmd;
		`CHK(t >= (AL + BL / 2) * TCK, 1'b1, "read ap too early")
		`CHK(t <= (AL + BL / 2) * TCK + 150.0, 1'b1, "read ap too late")
		count_busy(8'h04, 60, n);
		`CHK(n, dprt_pkg::T_RP_CYC, "read ap precharge length")
		`CHK(bank_open[2], 1'b0, "read ap left bank open")
		`CHK(all_idle, 1'b1, "not idle after read ap")
	endtask : sc_read_ap

	// write with auto-precharge waits for the burst and write recovery
	task automatic sc_write_ap;
		real lo;
		lo = (AL + CL - 1 + BL / 2) * TCK + dprt_pkg::T_WR_CYC * TCO;
		cmd(P_ACT, 3'h3, 1'b0, 1);
		cmd(P_WR, 3'h3, 1'b1, 1);
		wait_ap(3, t);
		t = t - dprt_ctrl_model_inst.t_cmd;
		`CHK(t >= lo, 1'b1, "write ap too early")
		`CHK(t <= lo + 150.0, 1'b1, "write ap too late")
		count_busy(8'h08, 60, n);
		`CHK(n, dprt_pkg::T_RP_CYC, "write ap precharge length")
		`CHK(bank_open[3], 1'b0, "write ap left bank open")
	endtask : sc_write_ap

	// precharge-all closes several open banks together
	task automatic sc_pre_all;
		cmd(P_ACT, 3'h4, 1'b0, 1);
		cmd(P_ACT, 3'h5, 1'b0, 4);
		repeat (10) @(posedge clock);
		`CHK(bank_open, 8'h30, "banks not opened")
		fork
			cmd(P_PRE, 3'h0, 1'b1, 1);
			count_busy(8'h30, 40, n);
		join
		`CHK(n, dprt_pkg::T_RP_CYC, "precharge-all length")
		`CHK(bank_open, 8'h00, "precharge-all left banks open")
		`CHK(all_idle, 1'b1, "not idle after precharge-all")
	endtask : sc_pre_all

	// two refreshes spaced by the 40-cycle busy count, then one with a bank open that does not step the row
	task automatic sc_refresh;
		r0 = refresh_row;
		for (int k = 1; k <= 2; k++) begin
			fork
				cmd(P_REF, 3'h5, 1'b1, 1);
				count_busy(8'hff, 40, n);
			join
			`CHK(n, dprt_pkg::T_RFC_CYC, "refresh length")
			`CHK(refresh_row, r0 + k[dprt_pkg::ROW_W-1:0], "refresh row step")
			`CHK(all_idle, 1'b1, "not idle after refresh")
		end
		cmd(P_ACT, 3'h6, 1'b0, 1);
		cmd(P_REF, 3'h0, 1'b0, 1);
		repeat (30) @(posedge clock);
		`CHK(refresh_row, r0 + 13'h0002, "refresh taken with open bank")
		`CHK(bank_open[6], 1'b1, "refresh closed an open bank")
		cmd(P_PRE, 3'h6, 1'b0, 1);
		repeat (dprt_pkg::T_RP_CYC + 12) @(posedge clock);
		`CHK(all_idle, 1'b1, "not idle at end")
	endtask : sc_refresh

	// main sequence; six core cycles still span enough link edges for its reset
	initial begin
		rst_n = 1'b0;
		errors = 0;
		checks = 0;
		cycles = 0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		sc_reset();
		repeat (4) @(posedge ck);
		sc_read_open();
		sc_read_ap();
		sc_write_ap();
		sc_pre_all();
		sc_refresh();
		wrap_up();
	end
endmodule : ddr2_precharge_refresh_timing_tb
